// >>> verilog/wdog_pkg.sv
/*
 * Package for the window watchdog: control word layout, reset value,
 * prescaler length and reset pulse timing.
 * Assumes a 200 MHz core clock; the reset pulse cycle count derives from that rate.
 */
`default_nettype none

package wdog_pkg;
    // Control word layout
    localparam int CTRL_WIDTH = 8;
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam int CNT_WIDTH = 7;
    localparam logic [7:0] CTRL_RESET = 8'h7F;
    localparam logic [6:0] CNT_RESET = 7'h7F;
    // Register offset of the control word
    localparam logic [7:0] CTRL_OFFSET = 8'h2E;
    // Machine cycles per countdown step
    localparam int PRESCALE_CYCLES = 16000;
    // Clock rate and reset pulse length
    localparam int CLK_MHZ = 200;
    localparam int PULSE_NS = 30000;
    localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ) / 1000;
endpackage : wdog_pkg

`default_nettype wire

// >>> verilog/window_watchdog_timer.sv
/*
 * Window watchdog: 7-bit free-running down-counter behind a machine-cycle
 * prescaler, control word on a plain register port, chip reset request
 * and an active-low reset pin drive.
 * Assumes machine_cycle_i marks CPU machine cycles, halt_i pulses when a
 * halt instruction executes, and option bits are stable from power-up.
 */
// Summary of operation
// - Counter steps down once every 16000 machine cycles via prescaler.
// - Active watchdog resets chip when counter falls from 0x40 to 0x3F.
// - Watchdog reset drives the reset pin low about thirty microseconds.
// - Counter runs while clk_en_i is high; only the reset action depends on activation.
// - Inactive after reset; once active, only a reset deactivates it.
// - Writing activation set with top bit clear gives a software reset.
// - Halt while active resets the chip unless halt option chosen.
// - Halt-without-reset option: halt and active-halt never reset.
// - Hardware option keeps watchdog always active; flag is unused.
// - Timeout programmable in 64 steps of one prescaler period.
// - At 8 MHz, 0xC0 gives 0-2 ms, 0xFF gives 126-128 ms.
// - Bit 7 activation, bits 6:0 counter, reset value 0x7F.
`timescale 1ns/1ps
`default_nettype none

module window_watchdog_timer
    import wdog_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES,
    parameter int PULSE = PULSE_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic machine_cycle_i,
    input wire logic halt_i,
    input wire logic hw_watchdog_option_i,
    input wire logic halt_without_reset_option_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic chip_reset_o,
    output logic reset_pin_o,
    output logic reset_pin_oe_o
);

    localparam int PW = $clog2(PRESCALE + 1);
    localparam int QW = $clog2(PULSE + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
    localparam logic [QW-1:0] PULSE_LAST = QW'(PULSE - 1);

    typedef enum logic [0:0] {IDLE, PULSING} pulse_state_t;

    logic [PW-1:0] pre_reg, pre_next;
    logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
    logic act_reg, act_next;
    logic [7:0] rdata_reg, rdata_next;
    pulse_state_t state_reg, state_next;
    logic [QW-1:0] pulse_reg, pulse_next;
    logic chip_reset_reg, chip_reset_next;
    logic pin_low_reg, pin_low_next;

    logic ctrl_wr;
    logic active_now;
    logic step;
    logic trigger;

    // Control word decode
    assign ctrl_wr = wr_i && (addr_i == CTRL_OFFSET);
    assign active_now = hw_watchdog_option_i || act_reg;

    // Counter, prescaler and activation next values
    always_comb
    begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        act_next = act_reg;
        step = 1'b0;
        if (machine_cycle_i)
        begin
            if (pre_reg == PRE_LAST)
            begin
                pre_next = '0;
                step = 1'b1;
            end
            else
            begin
                pre_next = pre_reg + 1'b1;
            end
        end
        if (step)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
        // Low six bits set delay; prescaler phase is left alone
        // Phase kept, so timeout spreads by one step
        if (ctrl_wr)
        begin
            cnt_next = wdata_i[CNT_WIDTH-1:0];
            // Flag only ever sets by write
            if (wdata_i[ACT_BIT])
            begin
                act_next = 1'b1;
            end
        end
    end

    // Reset trigger sources, evaluated on the pre-write state
    always_comb
    begin
        trigger = 1'b0;
        if (active_now && step && !ctrl_wr && cnt_reg[TOP_BIT]
            && !cnt_next[TOP_BIT])
        begin
            trigger = 1'b1;
        end
        if (ctrl_wr && wdata_i[ACT_BIT] == 1'b1 && !wdata_i[TOP_BIT])
        begin
            trigger = 1'b1;
        end
        // Hardware option makes any top-bit-clear write reset
        if (ctrl_wr && hw_watchdog_option_i && !wdata_i[TOP_BIT])
        begin
            trigger = 1'b1;
        end
        if (halt_i && active_now && !halt_without_reset_option_i)
        begin
            trigger = 1'b1;
        end
    end

    // Reset pulse sequencer; a one-cycle request plus a timed pin drive
    always_comb
    begin
        state_next = state_reg;
        pulse_next = pulse_reg;
        chip_reset_next = 1'b0;
        pin_low_next = pin_low_reg;
        case (state_reg)
            IDLE:
            begin
                if (trigger)
                begin
                    state_next = PULSING;
                    pulse_next = '0;
                    chip_reset_next = 1'b1;
                    pin_low_next = 1'b1;
                end
            end
            PULSING:
            begin
                if (pulse_reg == PULSE_LAST)
                begin
                    state_next = IDLE;
                    pin_low_next = 1'b0;
                end
                else
                begin
                    pulse_next = pulse_reg + 1'b1;
                end
            end
            default:
            begin
                state_next = IDLE;
                pin_low_next = 1'b0;
            end
        endcase
    end

    // Read data, valid the cycle after the strobe only
    always_comb
    begin
        rdata_next = 8'h00;
        // Flag in bit 7, counter below
        if (rd_i && addr_i == CTRL_OFFSET)
        begin
            rdata_next = {act_reg, cnt_reg};
        end
    end

    // Registers; the chip reset request loops back through rstn_i
    // Reset clears activation
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_reg <= '0;
            cnt_reg <= CNT_RESET;
            act_reg <= CTRL_RESET[ACT_BIT];
            rdata_reg <= 8'h00;
            state_reg <= IDLE;
            pulse_reg <= '0;
            chip_reset_reg <= 1'b0;
            pin_low_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            act_reg <= act_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            pulse_reg <= pulse_next;
            chip_reset_reg <= chip_reset_next;
            pin_low_reg <= pin_low_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign chip_reset_o = chip_reset_reg;
    // Open-drain pin: drive low only while pulsing
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = pin_low_reg;

endmodule : window_watchdog_timer

`default_nettype wire

// >>> verif/wdog_chk.sv
/* Port checker for window_watchdog_timer.
   Assumes the bind below and clk_en_i kept high while pulses run. */
`timescale 1ns/1ps
`default_nettype none
module wdog_chk
    import wdog_pkg::*;
#(
    parameter int PULSE = PULSE_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic halt_i,
    input wire logic hw_watchdog_option_i,
    input wire logic halt_without_reset_option_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic chip_reset_o,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o
);
    logic [15:0] oe_cnt_reg;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Counts pin drive cycles; one 16-bit counter is cheaper than a long repetition
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            oe_cnt_reg <= 16'h0000;
        else
            oe_cnt_reg <= reset_pin_oe_o ? oe_cnt_reg + 16'h0001 : 16'h0000;
    end
    a_pin_low: assert property (reset_pin_o == 1'b0)
        else $error("reset pin value not low");
    a_pulse_len: assert property ($fell(reset_pin_oe_o) |-> oe_cnt_reg == PULSE)
        else $error("reset pin drive length wrong");
    a_oe_with_req: assert property (chip_reset_o |-> $rose(reset_pin_oe_o))
        else $error("chip reset without pin drive start");
    a_req_one_cycle: assert property (chip_reset_o && clk_en_i |=> !chip_reset_o)
        else $error("chip reset longer than one cycle");
    a_soft_reset: assert property (wr_i && clk_en_i && addr_i == CTRL_OFFSET
        && wdata_i[7] && !wdata_i[6] && !reset_pin_oe_o |=> chip_reset_o)
        else $error("software reset missing");
    a_hw_halt_reset: assert property (halt_i && clk_en_i && hw_watchdog_option_i
        && !halt_without_reset_option_i && !reset_pin_oe_o |=> chip_reset_o)
        else $error("halt reset missing");
    a_read_idle: assert property (clk_en_i && !(rd_i && addr_i == CTRL_OFFSET)
        |=> rdata_o == 8'h00)
        else $error("read data not zero");
    a_no_retrigger: assert property (chip_reset_o |-> !$past(reset_pin_oe_o))
        else $error("trigger taken during pulse");
    c_reset: cover property (chip_reset_o);
    c_halt_opt: cover property (halt_i && halt_without_reset_option_i);
    c_write: cover property (wr_i && addr_i == CTRL_OFFSET);
endmodule : wdog_chk
bind window_watchdog_timer wdog_chk #(.PULSE(PULSE)) wdog_chk_inst (.*);
`default_nettype wire

// >>> verif/window_watchdog_timer_tb.sv
/* Self-checking bench for window_watchdog_timer.
   Assumes PRESCALE 4, PULSE 3, machine cycle every clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
$display("Error %0t %h %h", $time, a, b); end end
module window_watchdog_timer_tb;
    import wdog_pkg::*;
    logic clk = 0, rstn = 0, hw = 0, hnr = 0, halt = 0, wr = 0, rd = 0;
    logic ce = 1;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, rv;
    logic crst, pin, oe;
    int error_cnt = 0, check_count = 0, pulses = 0, seed = 17, k;
    always #2.5 clk = ~clk;
    // Count chip reset pulses as seen on the edge
    always @(posedge clk) if (crst === 1'b1) pulses++;
    window_watchdog_timer #(.PRESCALE(4), .PULSE(3)) window_watchdog_timer_inst (
        .core_clk_i(clk), .rstn_i(rstn), .clk_en_i(ce),
        .machine_cycle_i(1'b1), .halt_i(halt), .hw_watchdog_option_i(hw),
        .halt_without_reset_option_i(hnr), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .chip_reset_o(crst),
        .reset_pin_o(pin), .reset_pin_oe_o(oe));
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_b
    // Read data stands only in the cycle after the strobe
    task automatic rd_b(input logic [7:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
        @(posedge clk);
    endtask : rd_b
    // Bounded wait for a chip reset pulse; k gives the cycles taken
    task automatic expect_rst(input int n, input logic e);
        int p;
        p = pulses;
        k = 0;
        while (pulses == p && k < n)
        begin
            @(posedge clk);
            k++;
        end
        `CHK(pulses != p, e)
        if (e && pulses == p) close_out();
    endtask : expect_rst
    initial
    begin
        do_reset();
        rd_b(CTRL_OFFSET);
        `CHK(rv, CTRL_RESET)
        repeat (4)
        begin
            rv = $random(seed);
            wd <= rv;
            rd_b((rv == CTRL_OFFSET) ? 8'h00 : rv);
            `CHK(rv, 8'h00)
        end
        // inactive counter still runs past 0x40
        wr_b(CTRL_OFFSET, 8'h41);
        repeat (40) @(posedge clk);
        rd_b(CTRL_OFFSET);
        `CHK(rv inside {[8'h36:8'h37]}, 1'b1)
        `CHK(pulses, 0)
        // refresh value inside the allowed range
        // reset phase lies outside this block, not counted here
        wr_b(CTRL_OFFSET, 8'hC1);
        expect_rst(12, 1'b1);
        `CHK(k inside {[4:10]}, 1'b1)
        do_reset();
        wr_b(CTRL_OFFSET, 8'hFF);
        @(posedge clk);
        wr_b(CTRL_OFFSET, 8'h7F);
        rd_b(CTRL_OFFSET);
        `CHK(rv[7], 1'b1)
        repeat (3)
        begin
            do_reset();
            wr_b(CTRL_OFFSET, {2'b10, 6'($random(seed))});
            expect_rst(2, 1'b1);
        end
        // halt while active, then with option
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            hnr <= i[0];
            wr_b(CTRL_OFFSET, 8'hFF);
            halt <= 1'b1;
            @(posedge clk);
            halt <= 1'b0;
            expect_rst(3, !i[0]);
        end
        do_reset();
        hw <= 1'b1;
        wr_b(CTRL_OFFSET, 8'h3F);
        expect_rst(2, 1'b1);
        // halt resets with no flag under hardware option
        do_reset();
        hnr <= 1'b0;
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        expect_rst(3, 1'b1);
        // enable low freezes prescaler and counter
        do_reset();
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rd_b(CTRL_OFFSET);
        `CHK(rv, CTRL_RESET)
        close_out();
    end
endmodule : window_watchdog_timer_tb
`default_nettype wire
